// ---- core/spb_mac_end.sv ----
/*
 * MAC end of the segmented packet bus, plus its transmit word buffer.
 * Transmit cycles are checked, cleaned and buffered, then drained toward
 * the line side; line-side receive words are qualified onto the bus.
 * Assumes one core clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module spb_fifo
	import spb_pkg::*;
#(
	parameter int WIDTH = SPB_WORD_W,
	parameter int DEPTH = SPB_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH+1);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	logic push;
	logic pop;

	assign in_ready = count_r != FULL_CNT;
	assign out_valid = count_r != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_r];
	assign count = count_r;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_r <= '0;
		end else if (push) begin
			wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ptr_r <= '0;
		end else if (pop) begin
			rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_r <= '0;
		end else if (push != pop) begin
			count_r <= push ? count_r + 1'b1 : count_r - 1'b1;
		end
	end
endmodule : spb_fifo

module spb_mac_end
	import spb_pkg::*;
#(
	parameter int DEPTH = SPB_FIFO_DEPTH,
	parameter int SKID = SPB_TX_SKID
) (
	input wire logic clk,
	input wire logic rst,
	spb_bus_if.mac bus,
	output spb_word_t line_tx_word,
	output logic line_tx_valid,
	input wire logic line_tx_ready,
	input wire spb_word_t line_rx_word,
	output logic tx_seq_err
);
	localparam int CNT_W = $clog2(DEPTH+1);
	localparam logic [CNT_W-1:0] RDY_FREE = CNT_W'(SKID);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	spb_word_t tx_clean;
	spb_word_t rx_clean;
	spb_word_t rx_r;
	logic tx_any;
	logic fifo_in_ready;
	logic [CNT_W-1:0] fifo_count;
	logic ovf_r;
	logic seq_err_r;
	logic in_pkt_r;
	logic in_pkt_nxt;
	logic seq_bad;

	// per segment cleanup of transmit and receive segments
	for (genvar s = 0; s < SPB_SEG_N; s++) begin : g_seg
		always_comb begin
			tx_clean[s] = SPB_SEG_IDLE;
			if (bus.tx_seg[s].ena) begin
				tx_clean[s].ena = 1'b1;
				tx_clean[s].data = bus.tx_seg[s].data;
				tx_clean[s].packet_first_marker =
					bus.tx_seg[s].packet_first_marker;
				tx_clean[s].packet_last_marker =
					bus.tx_seg[s].packet_last_marker;
				if (bus.tx_seg[s].packet_last_marker) begin
					tx_clean[s].err = bus.tx_seg[s].err;
					tx_clean[s].mty = bus.tx_seg[s].mty;
					if (bus.tx_seg[s].err) begin
						tx_clean[s].mty[SPB_MTY_LOW_W-1:0] =
							SPB_MTY_LOW_ERR;
					end
				end
			end
		end

		always_comb begin
			rx_clean[s] = SPB_SEG_IDLE;
			if (line_rx_word[s].ena) begin
				rx_clean[s].ena = 1'b1;
				rx_clean[s].data = line_rx_word[s].data;
				rx_clean[s].packet_first_marker =
					line_rx_word[s].packet_first_marker;
				rx_clean[s].packet_last_marker =
					line_rx_word[s].packet_last_marker;
				if (line_rx_word[s].packet_last_marker) begin
					rx_clean[s].err = line_rx_word[s].err;
					rx_clean[s].mty = line_rx_word[s].mty;
				end
				if (rx_clean[s].err) begin
					rx_clean[s].mty[SPB_MTY_LOW_W-1:0] =
						SPB_MTY_LOW_ERR;
				end
			end
		end
	end

	// walk segments in order to follow packet boundaries
	always_comb begin
		in_pkt_nxt = in_pkt_r;
		seq_bad = 1'b0;
		for (int s = 0; s < SPB_SEG_N; s++) begin
			if (tx_clean[s].ena) begin
				if (tx_clean[s].packet_first_marker == in_pkt_nxt) begin
					seq_bad = 1'b1;
				end
				in_pkt_nxt = !tx_clean[s].packet_last_marker;
			end
		end
	end

	assign tx_any = tx_clean[0].ena;

	spb_fifo #(
		.WIDTH(SPB_WORD_W),
		.DEPTH(DEPTH)
	) u_tx_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(tx_any),
		.in_ready(fifo_in_ready),
		.in_data(tx_clean),
		.out_valid(line_tx_valid),
		.out_ready(line_tx_ready),
		.out_data(line_tx_word),
		.count(fifo_count)
	);

	// ready only while the skid allowance still fits
	assign bus.tx_rdy = (FULL_CNT - fifo_count) > RDY_FREE;

	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_r <= 1'b0;
		end else begin
			ovf_r <= tx_any && !fifo_in_ready;
		end
	end

	assign bus.tx_ovf = ovf_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			in_pkt_r <= 1'b0;
		end else if (tx_any && fifo_in_ready) begin
			in_pkt_r <= in_pkt_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			seq_err_r <= 1'b0;
		end else begin
			seq_err_r <= tx_any && fifo_in_ready && seq_bad;
		end
	end

	assign tx_seq_err = seq_err_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_r <= '0;
		end else begin
			rx_r <= rx_clean;
		end
	end

	assign bus.rx_seg = rx_r;
endmodule : spb_mac_end

// ---- core/spb_usr_end.sv ----
/*
 * User end of the segmented packet bus: registers application transmit
 * cycles onto the bus and hands qualified receive cycles to the user.
 * Assumes the application honours app_tx_ready and never stalls receive.
 */
`timescale 1ns/1ps
module spb_usr_end
	import spb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	spb_bus_if.usr bus,
	input wire spb_word_t app_tx_word,
	output logic app_tx_ready,
	output logic app_tx_ovf,
	output spb_word_t app_rx_word
);
	spb_word_t tx_clean;
	spb_word_t tx_r;
	spb_word_t rx_clean;
	spb_word_t rx_r;

	assign app_tx_ready = bus.tx_rdy;
	assign app_tx_ovf = bus.tx_ovf;

	for (genvar s = 0; s < SPB_SEG_N; s++) begin : g_seg
		logic chain;
		if (s == 0) begin : g_first
			assign chain = app_tx_word[0].ena;
		end else begin : g_rest
			assign chain = app_tx_word[s].ena && tx_clean[s-1].ena;
		end

		always_comb begin
			tx_clean[s] = SPB_SEG_IDLE;
			if (chain && app_tx_ready) begin
				tx_clean[s].ena = 1'b1;
				tx_clean[s].data = app_tx_word[s].data;
				tx_clean[s].packet_first_marker =
					app_tx_word[s].packet_first_marker;
				tx_clean[s].packet_last_marker =
					app_tx_word[s].packet_last_marker;
				if (app_tx_word[s].packet_last_marker) begin
					tx_clean[s].err = app_tx_word[s].err;
					tx_clean[s].mty = app_tx_word[s].mty;
				end
			end
		end

		always_comb begin
			rx_clean[s] = SPB_SEG_IDLE;
			if (bus.rx_seg[s].ena) begin
				rx_clean[s] = bus.rx_seg[s];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_r <= '0;
		end else begin
			tx_r <= tx_clean;
		end
	end

	assign bus.tx_seg = tx_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_r <= '0;
		end else begin
			rx_r <= rx_clean;
		end
	end

	assign app_rx_word = rx_r;
endmodule : spb_usr_end

// ---- shared/spb_bus_if.sv ----
/*
 * The segmented packet bus between the MAC end and the user end: four
 * segments each way plus the shared transmit ready and overflow signals.
 * Assumes both ends run on the same core clock, supplied to each module.
 */
`timescale 1ns/1ps
interface spb_bus_if;
	import spb_pkg::*;
	spb_word_t tx_seg;
	spb_word_t rx_seg;
	logic tx_rdy;
	logic tx_ovf;

	modport mac (
		input tx_seg,
		output rx_seg,
		output tx_rdy,
		output tx_ovf
	);

	modport usr (
		output tx_seg,
		input rx_seg,
		input tx_rdy,
		input tx_ovf
	);
endinterface : spb_bus_if

// ---- shared/spb_pkg.sv ----
/*
 * Shared constants and types for the segmented packet bus: segment layout,
 * bus width, transmit buffer depth and back-pressure allowance.
 * Assumes both ends and the buffer are compiled after this package.
 */
package spb_pkg;
	localparam int SPB_SEG_N = 4;
	localparam int SPB_DATA_W = 128;
	localparam int SPB_MTY_W = 4;
	localparam int SPB_BYTE_W = 8;
	localparam int SPB_FIFO_DEPTH = 16;
	// writes still allowed after the ready output falls
	localparam int SPB_TX_SKID = 4;
	// low empty-count bits forced on an errored last transfer
	localparam int SPB_MTY_LOW_W = 3;
	localparam logic [SPB_MTY_LOW_W-1:0] SPB_MTY_LOW_ERR = 3'h0;
	localparam logic [SPB_MTY_W-1:0] SPB_MTY_NONE = 4'h0;

	typedef struct packed {
		logic ena;
		logic packet_first_marker;
		logic packet_last_marker;
		logic err;
		logic [SPB_MTY_W-1:0] mty;
		logic [SPB_DATA_W-1:0] data;
	} spb_seg_t;

	localparam int SPB_SEG_W = $bits(spb_seg_t);

	typedef spb_seg_t [SPB_SEG_N-1:0] spb_word_t;

	localparam int SPB_WORD_W = $bits(spb_word_t);
	localparam spb_seg_t SPB_SEG_IDLE = '0;
endpackage : spb_pkg

// ---- test/segmented_packet_bus_if_tb.sv ----
/* testbench joining both bus ends through the interface.
   assumes the design files and package are compiled first. */
`timescale 1ns/1ps
module segmented_packet_bus_if_tb;
	import spb_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic line_tx_ready = 1'b0;
	logic line_tx_valid, app_tx_ready, app_tx_ovf, seq_err;
	logic ovf_seen = 1'b0;
	spb_word_t app_tx_word = '0;
	spb_word_t line_rx_word = '0;
	spb_word_t app_rx_word, line_tx_word, wi, we, bad, ew;
	int mismatches = 0;
	int n_tests = 0;
	spb_bus_if bus();
	spb_mac_end u_spb_mac_end(.clk(clk), .rst(rst), .bus(bus),
		.line_tx_word(line_tx_word), .line_tx_valid(line_tx_valid),
		.line_tx_ready(line_tx_ready), .line_rx_word(line_rx_word),
		.tx_seq_err(seq_err));
	spb_usr_end u_spb_usr_end(.clk(clk), .rst(rst), .bus(bus),
		.app_tx_word(app_tx_word), .app_tx_ready(app_tx_ready),
		.app_tx_ovf(app_tx_ovf), .app_rx_word(app_rx_word));
	spb_chk u_spb_chk(.clk(clk), .rst(rst), .tx_seg(bus.tx_seg),
		.rx_seg(bus.rx_seg), .tx_rdy(bus.tx_rdy), .tx_ovf(bus.tx_ovf));
	always #4 clk = ~clk;
	always @(posedge clk) if (app_tx_ovf === 1'b1) ovf_seen <= 1'b1;
	// control byte: ena, first, last, err, empty count
	function automatic spb_seg_t sg(input logic [7:0] c,
		input logic [127:0] d);
		return {c, d};
	endfunction : sg
	task automatic chk(input string nm, input logic [SPB_WORD_W-1:0] e, g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial begin
		#(8 * 1000);
		mismatches++;
		results();
	end
	initial begin
		wi = {sg(8'h7F, 128'h4444), sg(8'hD7, 128'h3333),
			sg(8'hBF, 128'h2222), sg(8'hC5, 128'h1111)};
		we = {SPB_SEG_IDLE, sg(8'hC0, 128'h3333),
			sg(8'hB8, 128'h2222), sg(8'hC0, 128'h1111)};
		bad = wi;
		bad[0].ena = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk) line_rx_word = wi;
		@(negedge clk) line_rx_word = '0;
		@(negedge clk) chk("rx", we, app_rx_word);
		app_tx_word = wi;
		@(negedge clk) app_tx_word = bad;
		@(negedge clk) app_tx_word = '0;
		chk("seq ok", '0, SPB_WORD_W'(seq_err));
		repeat (4) @(negedge clk);
		chk("tx", we, line_tx_word);
		line_tx_ready = 1'b1;
		@(negedge clk) line_tx_ready = 1'b0;
		chk("empty", '0, SPB_WORD_W'(line_tx_valid));
		for (int i = 0; i < 20; i++) begin
			app_tx_word[0] = sg(8'hE0, 128'(i));
			@(negedge clk);
		end
		app_tx_word = '0;
		repeat (3) @(negedge clk);
		chk("ready", '0, SPB_WORD_W'(app_tx_ready));
		line_tx_ready = 1'b1;
		for (int j = 0; j < 13; j++) begin
			ew = '0;
			ew[0] = sg(8'hE0, 128'(j));
			chk("drain", ew, line_tx_word);
			@(negedge clk);
		end
		chk("drained", '0, SPB_WORD_W'(line_tx_valid));
		repeat (20) @(negedge clk);
		chk("overflow", '0, SPB_WORD_W'(ovf_seen));
		// continuation segment outside any packet
		app_tx_word[0] = sg(8'hA0, 128'h5);
		@(negedge clk) app_tx_word = '0;
		@(negedge clk) chk("seq", 1, SPB_WORD_W'(seq_err));
		results();
	end
endmodule : segmented_packet_bus_if_tb

// ---- test/spb_assertions.sv ----
/* interface checker for the segmented packet bus.
   assumes one clock, synchronous active-high reset. */
`timescale 1ns/1ps
module spb_chk
	import spb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire spb_word_t tx_seg,
	input wire spb_word_t rx_seg,
	input wire logic tx_rdy,
	input wire logic tx_ovf
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	for (genvar s = 0; s < SPB_SEG_N; s++) begin : g_seg
		a_rx_idle_zero: assert property (
			!rx_seg[s].ena |-> rx_seg[s] == SPB_SEG_IDLE)
			else $error("rx idle segment not zero");
		a_tx_idle_zero: assert property (
			!tx_seg[s].ena |-> tx_seg[s] == SPB_SEG_IDLE)
			else $error("tx idle segment not zero");
		a_rx_err_low: assert property (
			rx_seg[s].err |-> rx_seg[s].mty[2:0] == SPB_MTY_LOW_ERR)
			else $error("rx error empty low bits set");
		a_rx_err_last: assert property (
			rx_seg[s].err |-> rx_seg[s].packet_last_marker)
			else $error("rx error without last marker");
		a_tx_mty_last: assert property (
			!tx_seg[s].packet_last_marker
				|-> tx_seg[s].mty == SPB_MTY_NONE && !tx_seg[s].err)
			else $error("tx empty or error off last");
		if (s > 0) begin : g_up
			a_tx_seg_contig: assert property (
				tx_seg[s].ena |-> tx_seg[s-1].ena)
				else $error("tx segments not contiguous");
		end
	end
	a_ovf_cause: assert property (
		tx_ovf |-> $past(!tx_rdy && tx_seg[0].ena))
		else $error("overflow without write while not ready");
	a_rdy_fall: assert property (
		$fell(tx_rdy) |-> $past(tx_seg[0].ena))
		else $error("ready fell without a write");
endmodule : spb_chk
